// file: cscs_defs.vh
// register map, field positions, reset values and timing constants of the serial channel
`ifndef CSCS_DEFS_VH
`define CSCS_DEFS_VH
// byte addresses of the registers on the register bus
`define CSCS_A_CLK_EN      12'h000
`define CSCS_A_PRESCALE    12'h004
`define CSCS_A_STOP        12'h008
`define CSCS_A_START       12'h00C
`define CSCS_A_MODE_HI     12'h010
`define CSCS_A_MODE_LO     12'h014
`define CSCS_A_COMM_HI     12'h018
`define CSCS_A_COMM_LO     12'h01C
`define CSCS_A_BAUD        12'h020
`define CSCS_A_CLK_OUT     12'h024
`define CSCS_A_DATA_OUT    12'h028
`define CSCS_A_OUT_EN      12'h02C
`define CSCS_A_FLAG_CLR    12'h030
`define CSCS_A_DATA        12'h034
`define CSCS_A_STATUS      12'h038
`define CSCS_A_RUNNING     12'h03C
// field positions
`define CSCS_B_CLK_EN      2
`define CSCS_B_MCK_SEL     7
`define CSCS_B_CCS_SEL     6
`define CSCS_B_STS_SEL     0
`define CSCS_B_MODE_HI     2
`define CSCS_B_MODE_LO     1
`define CSCS_B_IRQ_SRC     0
`define CSCS_B_TX_EN       7
`define CSCS_B_RX_EN       6
`define CSCS_B_DAP         5
`define CSCS_B_CKP         4
`define CSCS_B_ECC         2
`define CSCS_B_PTC_HI      1
`define CSCS_B_PTC_LO      0
`define CSCS_B_DIR         7
`define CSCS_B_SLC_HI      5
`define CSCS_B_SLC_LO      4
`define CSCS_B_DLS         0
`define CSCS_B_PECT        1
`define CSCS_B_OVCT        0
`define CSCS_B_OVF         0
`define CSCS_B_PEF         1
`define CSCS_B_BUSY        6
// reset values
`define CSCS_R_MODE_LO     8'h20
`define CSCS_R_COMM_HI     8'h87
`define CSCS_R_COMM_LO     8'h07
`define CSCS_R_OUT_EN      8'h00
`define CSCS_R_CLK_OUT     8'h01
`define CSCS_R_DATA_OUT    8'h01
// timing: word length and mode encodings
`define CSCS_BITS_LONG     4'h8
`define CSCS_BITS_SHORT    4'h7
`define CSCS_MODE_CSI      2'h0
`endif

// file: cscs_prescaler.v
// operation clock prescaler: one tick per 2^n pclk cycles
`timescale 1ns/1ns
`default_nettype none
module cscs_prescaler (
   // clock and reset
   input  wire       pclk,
   input  wire       presetn,
   // control
   input  wire       run,
   input  wire [3:0] sel,
   // tick out
   output reg        tick
);
   reg [14:0] cnt_q;
   wire [15:0] span;
   assign span = 16'h0001 << sel;

   // free counter, tick when the low sel bits are all ones
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 15'h0000;
         tick  <= 1'b0;
      end else if (!run) begin
         cnt_q <= 15'h0000;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 15'h0001;
         tick  <= (({1'b0, cnt_q} & (span - 16'h0001)) == (span - 16'h0001));
      end
   end
endmodule // cscs_prescaler
`default_nettype wire

// file: cscs_sync2.v
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ns
`default_nettype none
module cscs_sync2 (
   // clock and reset
   input  wire pclk,
   input  wire presetn,
   // level
   input  wire d,
   output reg  q
);
   reg meta_q;

   // first stage is read only by the second
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // cscs_sync2
`default_nettype wire

// file: cscs_channel.v
// clocked serial channel: apb registers, prescalers, baud divider and shift engine
`include "cscs_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module cscs_channel (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   // serial pins
   input  wire        sclk_in,
   input  wire        sdata_in,
   output reg         sclk_out,
   output reg         sdata_out,
   output reg         sdata_oe,
   // channel events
   output reg         chan_irq,
   output reg         chan_error_irq
);
   //--------------------------------------------------------------------
   // register state
   //--------------------------------------------------------------------
   reg [7:0] clk_en_q, prescale_q, mode_hi_q, mode_lo_q, comm_hi_q, comm_lo_q;
   reg [7:0] baud_q, clk_out_q, data_out_q, out_en_q, data_q;
   reg       chan_running_flag_q, overrun_flag_q, parity_err_flag_q;
   reg       full_q;
   wire      wr, rd, unit_on;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign unit_on = clk_en_q[`CSCS_B_CLK_EN];

   // decode of mapped addresses
   reg mapped;
   always @* begin
      case (paddr)
         `CSCS_A_CLK_EN, `CSCS_A_PRESCALE, `CSCS_A_STOP, `CSCS_A_START,
         `CSCS_A_MODE_HI, `CSCS_A_MODE_LO, `CSCS_A_COMM_HI, `CSCS_A_COMM_LO,
         `CSCS_A_BAUD, `CSCS_A_CLK_OUT, `CSCS_A_DATA_OUT, `CSCS_A_OUT_EN,
         `CSCS_A_FLAG_CLR, `CSCS_A_DATA, `CSCS_A_STATUS, `CSCS_A_RUNNING: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~mapped;

   //--------------------------------------------------------------------
   // operation clocks and transfer clock
   //--------------------------------------------------------------------
   wire ck0_tick, ck1_tick, mck_tick;
   cscs_prescaler u_ps0 (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (unit_on),
      .sel     (prescale_q[3:0]),
      .tick    (ck0_tick)
   );
   cscs_prescaler u_ps1 (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (unit_on),
      .sel     (prescale_q[7:4]),
      .tick    (ck1_tick)
   );
   assign mck_tick = mode_hi_q[`CSCS_B_MCK_SEL] ? ck1_tick : ck0_tick;

   // pin inputs pass two flops before use
   wire sclk_s, sdata_s;
   cscs_sync2 u_sync_clk (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (sclk_in),
      .q       (sclk_s)
   );
   cscs_sync2 u_sync_dat (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (sdata_in),
      .q       (sdata_s)
   );

   // half-period counter: mck/(2*(n+1)) gives one edge each n+1 ticks
   reg  [6:0] half_cnt_q;
   reg        sclk_s_q;
   wire       int_edge, ext_edge, edge_tick;
   assign int_edge = mck_tick & (half_cnt_q == baud_q[7:1]);
   assign ext_edge = sclk_s ^ sclk_s_q;
   // external clock drives slave transfers; both edges count as half periods
   assign edge_tick = mode_hi_q[`CSCS_B_CCS_SEL] ? ext_edge : int_edge;

   //--------------------------------------------------------------------
   // shift engine
   //--------------------------------------------------------------------
   localparam ST_IDLE  = 3'b001;
   localparam ST_SHIFT = 3'b010;
   localparam ST_DONE  = 3'b100;
   reg [2:0] st_q;
   reg [7:0] shreg_q;
   reg [3:0] bit_q;
   reg       phase_q;    // 0 first half of a bit, 1 second half
   reg       clk_act_q;  // engine clock level while shifting
   wire      csi_mode, tx_on, rx_on, dap, lsb_first, start_req;
   wire [3:0] nbits;
   assign csi_mode  = ({mode_lo_q[`CSCS_B_MODE_HI], mode_lo_q[`CSCS_B_MODE_LO]}
                       == `CSCS_MODE_CSI);
   assign tx_on     = comm_hi_q[`CSCS_B_TX_EN];
   assign rx_on     = comm_hi_q[`CSCS_B_RX_EN];
   assign dap       = comm_hi_q[`CSCS_B_DAP];
   assign lsb_first = comm_lo_q[`CSCS_B_DIR];
   assign nbits     = comm_lo_q[`CSCS_B_DLS] ? `CSCS_BITS_LONG : `CSCS_BITS_SHORT;
   // software write of the data register is the only start source here
   assign start_req = full_q & chan_running_flag_q & unit_on & csi_mode
                      & (tx_on | rx_on);

   wire       tx_bit, load_now, bit_last, sample_now, shift_now, launch_now;
   // msb of a short word sits at bit 6
   assign tx_bit   = lsb_first ? shreg_q[0] :
                     (comm_lo_q[`CSCS_B_DLS] ? shreg_q[7] : shreg_q[6]);
   assign load_now = (st_q == ST_IDLE) & start_req;
   assign bit_last = (bit_q == nbits - 4'h1);
   // type 1/2 sample at the second half, types 3/4 sample at the first
   assign sample_now = edge_tick & (st_q == ST_SHIFT) & (phase_q == dap);
   assign shift_now  = edge_tick & (st_q == ST_SHIFT) & phase_q;
   // data moves on the edge opposite to sampling, so the far side keeps hold time
   assign launch_now = (st_q == ST_SHIFT) & ((edge_tick & (phase_q != dap))
                       | (~dap & ~phase_q & (bit_q == 4'h0)));

   // half-period counter runs only while shifting
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_cnt_q  <= 7'h00;
         sclk_s_q    <= 1'b0;
      end else begin
         sclk_s_q    <= sclk_s;
         if (st_q != ST_SHIFT)
            half_cnt_q <= 7'h00;
         else if (mck_tick)
            half_cnt_q <= int_edge ? 7'h00 : half_cnt_q + 7'h01;
      end
   end

   // state machine: load, shift nbits, flag the end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q      <= ST_IDLE;
         shreg_q   <= 8'h00;
         bit_q     <= 4'h0;
         phase_q   <= 1'b0;
         clk_act_q <= 1'b0;
      end else if (!chan_running_flag_q || !unit_on) begin
         st_q      <= ST_IDLE;
         phase_q   <= 1'b0;
         clk_act_q <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (load_now) begin
                  shreg_q <= tx_on ? data_q : 8'hFF;
                  bit_q   <= 4'h0;
                  phase_q <= 1'b0;
                  st_q    <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (edge_tick) begin
                  clk_act_q <= ~clk_act_q;
                  phase_q   <= ~phase_q;
               end
               if (sample_now && rx_on) begin
                  // captured bit enters at the far end of the shift direction
                  if (lsb_first)
                     shreg_q <= {sdata_s, shreg_q[7:1]};
                  else if (comm_lo_q[`CSCS_B_DLS])
                     shreg_q <= {shreg_q[6:0], sdata_s};
                  else
                     shreg_q <= {1'b0, shreg_q[5:0], sdata_s};
               end else if (sample_now) begin
                  shreg_q <= lsb_first ? {1'b0, shreg_q[7:1]} : {shreg_q[6:0], 1'b0};
               end
               if (shift_now) begin
                  bit_q <= bit_q + 4'h1;
                  if (bit_last)
                     st_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               st_q      <= ST_IDLE;
               clk_act_q <= 1'b0;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   //--------------------------------------------------------------------
   // pin drivers
   //--------------------------------------------------------------------
   // engine owns the pins only while output is enabled
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_out  <= 1'b1;
         sdata_out <= 1'b1;
         sdata_oe  <= 1'b0;
      end else begin
         sdata_oe <= out_en_q[0] & tx_on;
         if (out_en_q[0] && st_q != ST_IDLE) begin
            // first move is away from the programmed idle level; done keeps the last bit
            sclk_out  <= clk_out_q[0] ^ clk_act_q;
            if (launch_now)
               sdata_out <= tx_on ? tx_bit : data_out_q[0];
         end else begin
            sclk_out  <= clk_out_q[0];
            sdata_out <= data_out_q[0];
         end
      end
   end

   //--------------------------------------------------------------------
   // register writes, flags and events
   //--------------------------------------------------------------------
   wire end_evt, empty_evt, overrun_evt, parity_evt;
   assign end_evt     = (st_q == ST_DONE) & chan_running_flag_q;
   assign empty_evt   = load_now;
   assign overrun_evt = end_evt & rx_on & full_q & ~load_now;
   assign parity_evt  = 1'b0; // no parity in clocked serial mode

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_en_q <= 8'h00;
         prescale_q <= 8'h00;
         mode_hi_q <= 8'h00;
         mode_lo_q <= `CSCS_R_MODE_LO;
         comm_hi_q <= `CSCS_R_COMM_HI;
         comm_lo_q <= `CSCS_R_COMM_LO;
         baud_q <= 8'h00;
         clk_out_q <= `CSCS_R_CLK_OUT;
         data_out_q <= `CSCS_R_DATA_OUT;
         out_en_q <= `CSCS_R_OUT_EN;
         data_q <= 8'h00;
         full_q <= 1'b0;
         chan_running_flag_q <= 1'b0;
         overrun_flag_q <= 1'b0;
         parity_err_flag_q <= 1'b0;
         chan_irq <= 1'b0;
         chan_error_irq <= 1'b0;
      end else begin
         // irq source bit picks buffer empty or transfer end
         chan_irq <= comm_hi_q[`CSCS_B_TX_EN] | comm_hi_q[`CSCS_B_RX_EN] ?
                     (mode_lo_q[`CSCS_B_IRQ_SRC] ? empty_evt : end_evt) : 1'b0;
         chan_error_irq <= (overrun_evt | parity_evt) & comm_hi_q[`CSCS_B_ECC];
         if (load_now)
            full_q <= 1'b0;
         if (end_evt && rx_on)
            data_q <= shreg_q & (comm_lo_q[`CSCS_B_DLS] ? 8'hFF : 8'h7F);
         if (wr) begin
            case (paddr)
               `CSCS_A_CLK_EN:   clk_en_q <= pwdata[7:0];
               `CSCS_A_PRESCALE: prescale_q <= pwdata[7:0];
               `CSCS_A_STOP:     if (pwdata[0]) chan_running_flag_q <= 1'b0;
               `CSCS_A_START:    if (pwdata[0]) chan_running_flag_q <= 1'b1;
               // only the two clock-select bits hold state; start source is absent
               `CSCS_A_MODE_HI:  mode_hi_q <= pwdata[7:0] & 8'hC0;
               `CSCS_A_MODE_LO:  mode_lo_q <= (pwdata[7:0] & 8'h07) | 8'h20;
               // parity and stop fields stored for uart use only
               `CSCS_A_COMM_HI:  comm_hi_q <= pwdata[7:0] & 8'hF7;
               `CSCS_A_COMM_LO:  comm_lo_q <= (pwdata[7:0] & 8'hB1) | 8'h06;
               `CSCS_A_BAUD:     baud_q <= pwdata[7:0] & 8'hFE;
               `CSCS_A_CLK_OUT:  clk_out_q <= pwdata[7:0] & 8'h01;
               `CSCS_A_DATA_OUT: data_out_q <= pwdata[7:0] & 8'h01;
               `CSCS_A_OUT_EN:   out_en_q <= pwdata[7:0] & 8'h01;
               `CSCS_A_DATA: begin
                  data_q <= pwdata[7:0] & (comm_lo_q[`CSCS_B_DLS] ? 8'hFF : 8'h7F);
                  full_q <= 1'b1;
               end
               default: ;
            endcase
         end
         // set wins over a clear in the same cycle
         if (wr && paddr == `CSCS_A_FLAG_CLR && pwdata[`CSCS_B_OVCT])
            overrun_flag_q <= 1'b0;
         if (overrun_evt)
            overrun_flag_q <= 1'b1;
         if (wr && paddr == `CSCS_A_FLAG_CLR && pwdata[`CSCS_B_PECT])
            parity_err_flag_q <= 1'b0;
         if (parity_evt)
            parity_err_flag_q <= 1'b1;
      end
   end

   // read mux; write-only triggers read as zero
   always @* begin
      prdata = 32'h00000000;
      if (rd) begin
         case (paddr)
            `CSCS_A_CLK_EN:   prdata = {24'h000000, clk_en_q};
            `CSCS_A_PRESCALE: prdata = {24'h000000, prescale_q};
            `CSCS_A_MODE_HI:  prdata = {24'h000000, mode_hi_q};
            `CSCS_A_MODE_LO:  prdata = {24'h000000, mode_lo_q};
            `CSCS_A_COMM_HI:  prdata = {24'h000000, comm_hi_q};
            `CSCS_A_COMM_LO:  prdata = {24'h000000, comm_lo_q};
            `CSCS_A_BAUD:     prdata = {24'h000000, baud_q};
            `CSCS_A_CLK_OUT:  prdata = {24'h000000, clk_out_q};
            `CSCS_A_DATA_OUT: prdata = {24'h000000, data_out_q};
            `CSCS_A_OUT_EN:   prdata = {24'h000000, out_en_q};
            `CSCS_A_DATA:     prdata = {24'h000000, data_q};
            `CSCS_A_STATUS:   prdata = {25'h0000000, (st_q != ST_IDLE), 4'h0,
                                        parity_err_flag_q, overrun_flag_q};
            `CSCS_A_RUNNING:  prdata = {31'h00000000, chan_running_flag_q};
            default:          prdata = 32'h00000000;
         endcase
      end
   end
endmodule // cscs_channel
`default_nettype wire

// file: cscs_chk_props.sv
// checker of the serial channel: bus decode, pin levels and clock pacing
`timescale 1ns/1ns
`default_nettype none
`include "cscs_defs.vh"
module cscs_chk_props (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // register bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // serial pins and events
   input wire logic        sclk_in,
   input wire logic        sdata_in,
   input wire logic        sclk_out,
   input wire logic        sdata_out,
   input wire logic        sdata_oe,
   input wire logic        chan_irq,
   input wire logic        chan_error_irq
);
   logic        acc, wr, bad, prev_q, en_q, run_q, cko_q, so_q;
   logic [7:0]  sps_q, mhi_q, baud_q;
   logic [3:0]  psc;
   logic [23:0] gap_q, half;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // pacing depends on prescaler, clock pick and divider, so mirror them
   assign acc  = psel & penable;
   assign wr   = acc & pwrite & pready;
   assign bad  = (paddr[1:0] != 2'h0) || (paddr > `CSCS_A_RUNNING);
   assign psc  = mhi_q[`CSCS_B_MCK_SEL] ? sps_q[7:4] : sps_q[3:0];
   assign half = ({17'h0, baud_q[7:1]} + 24'h1) << psc;
   // settings as software last wrote them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q   <= 1'b0;
         run_q  <= 1'b0;
         cko_q  <= 1'b1;
         so_q   <= 1'b1;
         sps_q  <= 8'h00;
         mhi_q  <= 8'h00;
         baud_q <= 8'h00;
      end else if (wr) begin
         case (paddr)
            `CSCS_A_CLK_EN:   en_q   <= pwdata[`CSCS_B_CLK_EN];
            `CSCS_A_PRESCALE: sps_q  <= pwdata[7:0];
            `CSCS_A_MODE_HI:  mhi_q  <= pwdata[7:0];
            `CSCS_A_BAUD:     baud_q <= pwdata[7:0];
            `CSCS_A_CLK_OUT:  cko_q  <= pwdata[0];
            `CSCS_A_DATA_OUT: so_q   <= pwdata[0];
            `CSCS_A_START:    run_q  <= run_q | pwdata[0];
            `CSCS_A_STOP:     run_q  <= run_q & ~pwdata[0];
            default:          en_q   <= en_q;
         endcase
      end
   end
   // cycles the clock pin has held since it last moved
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b1;
         gap_q  <= 24'h0;
      end else begin
         prev_q <= sclk_out;
         gap_q  <= (sclk_out != prev_q) ? 24'h0 : gap_q + 24'h1;
      end
   end
   a_ready_high: assert property (pready)
      else $error("ready dropped");
   a_err_decode: assert property (pslverr == (acc && bad))
      else $error("error response does not match decode");
   a_rdata_quiet: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
      else $error("read data outside read access");
   a_irq_pulse: assert property (chan_irq |=> !chan_irq)
      else $error("transfer event longer than one cycle");
   a_clk_idle: assert property ($changed(sclk_out) && sclk_out != cko_q |-> run_q && en_q)
      else $error("clock pin left idle while stopped or unclocked");
   a_clk_level: assert property (wr && paddr == `CSCS_A_CLK_OUT && !run_q
      |=> ##[0:1] sclk_out == cko_q)
      else $error("clock pin ignores its level bit");
   a_data_level: assert property (wr && paddr == `CSCS_A_DATA_OUT && !run_q
      |=> ##[0:1] sdata_out == so_q)
      else $error("data pin ignores its level bit");
   a_oe_on: assert property (wr && paddr == `CSCS_A_OUT_EN && pwdata[0]
      |=> ##[0:1] sdata_oe)
      else $error("output enable not granted");
   a_baud_half: assert property ($changed(sclk_out) && sclk_out == cko_q && run_q
      |-> gap_q == half - 24'h1)
      else $error("clock half period off");
endmodule // cscs_chk_props
bind cscs_channel cscs_chk_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .sclk_in(sclk_in), .sdata_in(sdata_in),
   .sclk_out(sclk_out), .sdata_out(sdata_out), .sdata_oe(sdata_oe), .chan_irq(chan_irq),
   .chan_error_irq(chan_error_irq));
`default_nettype wire

// file: cscs_serial_slave.sv
// far-side serial slave: shifts a byte in while shifting its own byte out
`timescale 1ns/1ns
`default_nettype none
module cscs_serial_slave (
   // serial lines
   input  wire logic       sclk,
   input  wire logic       mosi,
   output var  logic       sdata,
   // test control
   input  wire logic       load,
   input  wire logic [7:0] tx_byte,
   output var  logic [7:0] rx_byte
);
   logic [7:0] sh_q = 8'hFF;
   logic       first_q = 1'b1;
   // sample on the trailing edge of each bit
   always @(posedge sclk) begin
      rx_byte <= {rx_byte[6:0], mosi};
   end
   // launch on the leading edge; spent bits refill inverted so the line keeps moving
   always @(negedge sclk or posedge load) begin
      if (load) begin
         sh_q    <= tx_byte;
         first_q <= 1'b1;
      end else if (first_q) begin
         first_q <= 1'b0;
      end else begin
         sh_q <= {sh_q[6:0], ~sh_q[7]};
      end
   end
   assign sdata = sh_q[7];
endmodule // cscs_serial_slave
`default_nettype wire

// file: cscs_channel_bench.sv
// self-checking bench of the serial channel with a far-side slave
`timescale 1ns/1ns
`default_nettype none
`include "cscs_defs.vh"
module cscs_channel_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sload, er;
   logic        sclk_out, sdata_out, sdata_oe, sdata_in, chan_irq, chan_error_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  stx, srx;
   int          fail_count, checked, nfall, nirq;
   cscs_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .sclk_in(1'b0), .sdata_in(sdata_in), .sclk_out(sclk_out),
      .sdata_out(sdata_out), .sdata_oe(sdata_oe), .chan_irq(chan_irq),
      .chan_error_irq(chan_error_irq));
   cscs_serial_slave u_slave (.sclk(sclk_out), .mosi(sdata_out), .sdata(sdata_in),
      .load(sload), .tx_byte(stx), .rx_byte(srx));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // clock pulses and transfer events seen on the pins
   always @(negedge sclk_out) nfall++;
   always @(posedge pclk) if (chan_irq === 1'b1) nirq++;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // one bus transfer; holds the request until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask
   task automatic t_reset();
      logic [11:0] ra [6] = '{`CSCS_A_MODE_LO, `CSCS_A_COMM_HI, `CSCS_A_COMM_LO,
                              `CSCS_A_OUT_EN, `CSCS_A_CLK_OUT, `CSCS_A_DATA_OUT};
      logic [7:0]  rv [6] = '{`CSCS_R_MODE_LO, `CSCS_R_COMM_HI, `CSCS_R_COMM_LO,
                              `CSCS_R_OUT_EN, `CSCS_R_CLK_OUT, `CSCS_R_DATA_OUT};
      chk(sclk_out, 32'h1, "clock idle");
      chk(sdata_out, 32'h1, "data idle");
      chk(sdata_oe, 32'h0, "enable idle");
      for (int i = 0; i < 6; i++) rdchk(ra[i], {24'h0, rv[i]}, "reset value");
      $display("test reset done");
   endtask
   task automatic t_regs();
      logic [11:0] ra [4] = '{`CSCS_A_COMM_HI, `CSCS_A_COMM_LO, `CSCS_A_BAUD, `CSCS_A_PRESCALE};
      logic [7:0]  rv [4] = '{8'hF0, 8'h87, 8'h26, 8'h5A};
      for (int i = 0; i < 4; i++) begin
         wr(ra[i], rv[i]);
         rdchk(ra[i], {24'h0, rv[i]}, "readback");
      end
      rdchk(12'h040, 32'h0, "unmapped read");
      chk(er, 32'h1, "unmapped read refused");
      wr(12'h040, 8'hFF);
      chk(er, 32'h1, "unmapped write refused");
      $display("test registers done");
   endtask
   // trigger writes: only a 1 acts
   task automatic t_run();
      logic [11:0] ra [4] = '{`CSCS_A_START, `CSCS_A_START, `CSCS_A_STOP, `CSCS_A_STOP};
      logic [7:0]  rv [4] = '{8'h00, 8'h01, 8'h00, 8'h01};
      logic [31:0] ex [4] = '{32'h0, 32'h1, 32'h1, 32'h0};
      wr(`CSCS_A_CLK_EN, 8'h04);
      for (int i = 0; i < 4; i++) begin
         wr(ra[i], rv[i]);
         rdchk(`CSCS_A_RUNNING, ex[i], "running flag");
      end
      $display("test triggers done");
   endtask
   // one word with set-up order of software kept
   task automatic t_xfer(input logic [7:0] lo, input logic [7:0] ps, input logic [7:0] tx,
                         input logic [7:0] mine);
      logic [7:0] es, ed, mk;
      int nb, n, ix;
      nb = lo[0] ? 8 : 7;
      es = 8'h00;
      ed = 8'h00;
      mk = lo[0] ? 8'hFF : 8'h7F;
      for (int k = 0; k < nb; k++) begin
         ix = lo[7] ? k : nb - 1 - k;
         es[nb - 1 - k] = tx[ix];
         ed[ix] = mine[7 - k];
      end
      wr(`CSCS_A_STOP, 8'h01);
      wr(`CSCS_A_MODE_HI, 8'h00);
      wr(`CSCS_A_MODE_LO, 8'h20);
      wr(`CSCS_A_COMM_HI, 8'hF0);
      wr(`CSCS_A_COMM_LO, lo);
      wr(`CSCS_A_PRESCALE, ps);
      wr(`CSCS_A_BAUD, 8'h08);
      wr(`CSCS_A_OUT_EN, 8'h01);
      wr(`CSCS_A_START, 8'h01);
      stx <= mine;
      sload <= 1'b1;
      @(posedge pclk);
      sload <= 1'b0;
      nfall = 0;
      nirq = 0;
      wr(`CSCS_A_DATA, tx);
      n = 0;
      while (nirq == 0 && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      repeat (4) @(posedge pclk);
      chk(nfall, nb, "clock pulses");
      chk(nirq, 32'h1, "transfer events");
      chk(sclk_out, 32'h1, "clock back idle");
      chk({24'h0, srx & mk}, {24'h0, es}, "word sent");
      rdchk(`CSCS_A_DATA, {24'h0, ed}, "word received");
      $display("test transfer done");
   endtask
   // with the unit clock supply off no word may move
   task automatic t_noclk();
      wr(`CSCS_A_CLK_EN, 8'h00);
      nfall = 0;
      wr(`CSCS_A_DATA, 8'h33);
      repeat (300) @(posedge pclk);
      chk(nfall, 32'h0, "clock without supply");
      wr(`CSCS_A_STOP, 8'h01);
      wr(`CSCS_A_CLK_OUT, 8'h00);
      wr(`CSCS_A_DATA_OUT, 8'h00);
      repeat (2) @(posedge pclk);
      chk(sclk_out, 32'h0, "clock level bit");
      chk(sdata_out, 32'h0, "data level bit");
      $display("test supply done");
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      fail_count++;
      close_out();
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sload = 1'b0;
      stx = 8'hFF;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_regs();
      t_run();
      t_xfer(8'h07, 8'h00, 8'hA5, 8'h3C);
      t_xfer(8'h87, 8'h00, 8'h96, 8'hC1);
      t_xfer(8'h06, 8'h01, 8'h5A, 8'hB7);
      t_noclk();
      close_out();
   end
endmodule // cscs_channel_bench
`default_nettype wire
